// ### hdl/php_regs.vh
// register map, entry field positions and encodings for the page history and protection block
`ifndef PHP_REGS_VH
`define PHP_REGS_VH

// apb register byte offsets
`define PHP_OFF_CTRL      8'h00
`define PHP_OFF_PTBASE    8'h04
`define PHP_OFF_DCAUSE    8'h08
`define PHP_OFF_SAVED     8'h0C
`define PHP_OFF_STATUS    8'h10

// control and status bit positions
`define PHP_CTRL_INV      0
`define PHP_STAT_BUSY     0
`define PHP_STAT_SHARED   1

// reset values
`define PHP_PTBASE_RST    32'h00000000
`define PHP_ZERO32        32'h00000000

// second entry word, little-endian positions (bit n here is bit 31-n in the entry figure)
`define PHP_W1_R          8
`define PHP_W1_C          7
`define PHP_W1_W          6
`define PHP_W1_I          5
`define PHP_W1_PP_HI      1
`define PHP_W1_PP_LO      0
`define PHP_W1_PPN_HI     31
`define PHP_W1_PPN_LO     12

// fault cause positions (bit 4 and bit 6 counted from the msb)
`define PHP_CAUSE_PROT    27
`define PHP_CAUSE_STORE   25

// logical address split
`define PHP_PAGE_HI       31
`define PHP_PAGE_LO       12
`define PHP_OFS_HI        11
`define PHP_OFS_LO        0

// entry address: base + page * 8 + 4 selects the second word
`define PHP_ENTRY_PAD     9'h000
`define PHP_ENTRY_LOW     3'h4

// access kinds from the pipelines
`define PHP_K_LOAD        3'h0
`define PHP_K_STORE       3'h1
`define PHP_K_FETCH       3'h2
`define PHP_K_TOUCHL      3'h3
`define PHP_K_TOUCHS      3'h4
`define PHP_K_ZERO        3'h5

// page protection encodings
`define PHP_PP_K0RW       2'h0
`define PHP_PP_K1RO       2'h1
`define PHP_PP_RW         2'h2

`endif

// ### hdl/php_page_history_protect.v
// page history recording and page protection check with a small translation cache
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "php_regs.vh"

// Behaviour
// - no history for block map translations or io segment accesses
// - history kept only while the relevant translation enable is on
// - on cache miss the entry search also sets touched and dirty as needed
// - hit pattern 10: read does nothing, allowed store sets cached dirty, searches memory
// - hit pattern 11: no history update for read or write
// - every cache entry is filled with its touched flag set
// - on hit the dirty update depends only on the cached dirty flag
// - cache touch operations never set touched or dirty flags
// - each entry search sets touched in memory; hardware never clears it
// - touched may be set by unexecuted fetches and faulting accesses
// - dirty set in cache and memory only when protection permits the store
// - memory flag updates use separate single-beat reads and writes, not atomics
// - entry fetches are global nonexclusive reads, never read-with-intent-to-modify
// - after a cache match the access is checked against page protection
// - prohibited data access: data exception, cause bit 4, plus bit 6 for stores
// - prohibited fetch: instruction exception, saved state bit 4 set
// - prohibited store may still fill the cache and set touched
// - line zero on write-through or cache-inhibited page raises alignment exception
// - touched flag is entry word bit 23, dirty flag bit 24
module php_page_history_protect #(
  parameter IDX_W = 4
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // pipeline request
  input  wire        reqValid,
  output wire        reqReady,
  input  wire [2:0]  reqKind,
  input  wire [31:0] reqAddr,
  input  wire        reqKey,
  input  wire        reqBlockMapHit,
  input  wire        reqIoSeg,
  input  wire        instrXlateOn,
  input  wire        dataXlateOn,
  // pipeline answer
  output reg         rspValid,
  output reg  [31:0] rspPhysAddr,
  output reg         rspDataExc,
  output reg         rspInstrExc,
  output reg         rspAlignExc,
  // system bus master
  output reg         busReq,
  output reg         busWrite,
  output reg  [31:0] busAddr,
  output reg  [31:0] busWdata,
  output wire        busGlobal,
  output wire        busRwitm,
  output wire        busSingleBeat,
  input  wire        busAck,
  input  wire [31:0] busRdata,
  input  wire        shared_resp
);

  localparam DEPTH   = 1 << IDX_W;
  localparam S_IDLE  = 2'h0;
  localparam S_READ  = 2'h1;
  localparam S_WRITE = 2'h2;

  // translation cache storage
  reg  [19:0]      cacheTag_ff [0:DEPTH-1];
  reg  [31:0]      cacheW1_ff  [0:DEPTH-1];
  reg  [DEPTH-1:0] cacheVld_ff;

  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [2:0]       kind_ff;
  reg  [2:0]       nxt_kind;
  reg  [31:0]      addr_ff;
  reg  [31:0]      nxt_addr;
  reg              key_ff;
  reg              nxt_key;
  reg              hit_ff;
  reg              nxt_hit;
  reg              pendProt_ff;
  reg              nxt_pendProt;
  reg              pendAlign_ff;
  reg              nxt_pendAlign;
  reg  [31:0]      pendPhys_ff;
  reg  [31:0]      nxt_pendPhys;
  reg  [31:0]      ptBase_ff;
  reg  [31:0]      dataFaultCause_ff;
  reg  [31:0]      faultSavedState_ff;
  reg              lastShared_ff;
  reg              nxt_busReq;
  reg              nxt_busWrite;
  reg  [31:0]      nxt_busAddr;
  reg  [31:0]      nxt_busWdata;

  // finishing strobes and cache write port, decided in the comb block
  reg              fin;
  reg              finProt;
  reg              finAlign;
  reg  [31:0]      finPhys;
  reg              cacheWe;
  reg  [IDX_W-1:0] cacheWIdx;
  reg  [19:0]      cacheWTag;
  reg  [31:0]      cacheWData;

  // request decode
  wire [19:0]      reqPage    = reqAddr[`PHP_PAGE_HI:`PHP_PAGE_LO];
  wire [IDX_W-1:0] reqIdx     = reqAddr[`PHP_PAGE_LO+IDX_W-1:`PHP_PAGE_LO];
  wire [31:0]      hitW1      = cacheW1_ff[reqIdx];
  wire             hitNow     = cacheVld_ff[reqIdx] && (cacheTag_ff[reqIdx] == reqPage);
  wire             reqFetch   = (reqKind == `PHP_K_FETCH);
  wire             reqTouch   = (reqKind == `PHP_K_TOUCHL) || (reqKind == `PHP_K_TOUCHS);
  wire             reqZero    = (reqKind == `PHP_K_ZERO);
  wire             reqWr      = (reqKind == `PHP_K_STORE) || reqZero;
  wire             reqXlate   = reqFetch ? instrXlateOn : dataXlateOn;
  wire             reqBypass  = !reqXlate || reqBlockMapHit || reqIoSeg;
  wire             hitCached  = hitW1[`PHP_W1_C];
  wire             hitAlign   = reqZero && (hitW1[`PHP_W1_W] || hitW1[`PHP_W1_I]);
  wire [31:0]      entryAddr  = ptBase_ff + {`PHP_ENTRY_PAD, reqPage, `PHP_ENTRY_LOW};
  wire [31:0]      hitPhys    = {hitW1[`PHP_W1_PPN_HI:`PHP_W1_PPN_LO], reqAddr[`PHP_OFS_HI:`PHP_OFS_LO]};

  // latched request decode for the memory path
  wire [IDX_W-1:0] curIdx     = addr_ff[`PHP_PAGE_LO+IDX_W-1:`PHP_PAGE_LO];
  wire             curZero    = (kind_ff == `PHP_K_ZERO);
  wire             curWr      = (kind_ff == `PHP_K_STORE) || curZero;
  wire             memAlign   = curZero && (busRdata[`PHP_W1_W] || busRdata[`PHP_W1_I]);
  wire             memPermit;
  wire             memSetC    = curWr && memPermit && !memAlign;
  wire [31:0]      memNew     = busRdata | (`PHP_ZERO32 | ({31'h00000000, 1'b1} << `PHP_W1_R))
                                         | ({31'h00000000, memSetC} << `PHP_W1_C);
  wire [31:0]      memPhys    = {busRdata[`PHP_W1_PPN_HI:`PHP_W1_PPN_LO], addr_ff[`PHP_OFS_HI:`PHP_OFS_LO]};

  // page protection from key and pp bits; fetches count as reads
  function permit;
    input [1:0] pp;
    input       key;
    input       wr;
    begin
      case (pp)
        `PHP_PP_K0RW: permit = ~key;
        `PHP_PP_K1RO: permit = ~key | ~wr;
        `PHP_PP_RW:   permit = 1'b1;
        default:      permit = ~wr;
      endcase
    end
  endfunction

  wire hitPermit = permit(hitW1[`PHP_W1_PP_HI:`PHP_W1_PP_LO], reqKey, reqWr);
  assign memPermit = permit(busRdata[`PHP_W1_PP_HI:`PHP_W1_PP_LO], key_ff, curWr);

  // entry traffic is always a global plain read or plain write, one beat each
  assign busGlobal     = 1'b1;
  assign busRwitm      = 1'b0;
  assign busSingleBeat = 1'b1;
  assign reqReady      = (state_ff == S_IDLE);
  assign pready        = 1'b1;

  // main sequencing: lookup in idle, then optional entry read and write-back
  always @* begin
    nxt_state     = state_ff;
    nxt_kind      = kind_ff;
    nxt_addr      = addr_ff;
    nxt_key       = key_ff;
    nxt_hit       = hit_ff;
    nxt_pendProt  = pendProt_ff;
    nxt_pendAlign = pendAlign_ff;
    nxt_pendPhys  = pendPhys_ff;
    nxt_busReq    = busReq;
    nxt_busWrite  = busWrite;
    nxt_busAddr   = busAddr;
    nxt_busWdata  = busWdata;
    fin           = 1'b0;
    finProt       = 1'b0;
    finAlign      = 1'b0;
    finPhys       = reqAddr;
    cacheWe       = 1'b0;
    cacheWIdx     = reqIdx;
    cacheWTag     = reqPage;
    cacheWData    = hitW1;
    case (state_ff)
      S_IDLE: begin
        if (reqValid) begin
          nxt_kind    = reqKind;
          nxt_addr    = reqAddr;
          nxt_key     = reqKey;
          nxt_hit     = hitNow;
          nxt_busAddr = entryAddr;
          if (reqBypass) begin
            // untranslated, block mapped or io segment: pass through, no history
            fin = 1'b1;
          end else if (reqTouch) begin
            // touch hints never start a search nor mark the page
            fin     = 1'b1;
            finPhys = hitNow ? hitPhys : reqAddr;
          end else if (hitNow) begin
            finPhys = hitPhys;
            if (hitAlign) begin
              fin      = 1'b1;
              finAlign = 1'b1;
            end else if (!hitPermit) begin
              fin     = 1'b1;
              finProt = 1'b1;
            end else if (reqWr && !hitCached) begin
              // pattern 10 store: mark cached copy now, then fix memory
              cacheWe       = 1'b1;
              cacheWData    = hitW1 | ({31'h00000000, 1'b1} << `PHP_W1_C);
              nxt_pendProt  = 1'b0;
              nxt_pendAlign = 1'b0;
              nxt_pendPhys  = hitPhys;
              nxt_busReq    = 1'b1;
              nxt_busWrite  = 1'b0;
              nxt_state     = S_READ;
            end else begin
              fin = 1'b1;
            end
          end else begin
            // miss: fetch the second entry word to fill and mark history
            nxt_busReq   = 1'b1;
            nxt_busWrite = 1'b0;
            nxt_state    = S_READ;
          end
        end
      end
      S_READ: begin
        if (busAck) begin
          nxt_busReq = 1'b0;
          cacheWIdx  = curIdx;
          cacheWTag  = addr_ff[`PHP_PAGE_HI:`PHP_PAGE_LO];
          cacheWData = memNew;
          // fill keeps touched set even for a faulting access
          cacheWe = !hit_ff;
          if (!hit_ff) begin
            nxt_pendAlign = memAlign;
            nxt_pendProt  = !memAlign && !memPermit;
            nxt_pendPhys  = memPhys;
          end
          if (memNew != busRdata) begin
            // separate write of the same word, other fields as read
            nxt_busReq   = 1'b1;
            nxt_busWrite = 1'b1;
            nxt_busWdata = memNew;
            nxt_state    = S_WRITE;
          end else begin
            fin       = 1'b1;
            finProt   = hit_ff ? 1'b0 : (!memAlign && !memPermit);
            finAlign  = hit_ff ? 1'b0 : memAlign;
            finPhys   = hit_ff ? pendPhys_ff : memPhys;
            nxt_state = S_IDLE;
          end
        end
      end
      S_WRITE: begin
        if (busAck) begin
          nxt_busReq   = 1'b0;
          nxt_busWrite = 1'b0;
          fin          = 1'b1;
          finProt      = pendProt_ff;
          finAlign     = pendAlign_ff;
          finPhys      = pendPhys_ff;
          nxt_state    = S_IDLE;
        end
      end
      default: begin
        nxt_state  = S_IDLE;
        nxt_busReq = 1'b0;
      end
    endcase
  end

  // apb decode; a write lands in the access phase, read data is captured in setup
  wire apbWr     = psel && penable && pwrite;
  wire apbSetup  = psel && !penable;
  wire invAll    = apbWr && (paddr == `PHP_OFF_CTRL) && pwdata[`PHP_CTRL_INV];
  wire curFetch  = (state_ff == S_IDLE) ? reqFetch : (kind_ff == `PHP_K_FETCH); // stale kind ignored when idle
  wire faultData = fin && finProt && !curFetch;
  wire faultInst = fin && finProt && curFetch;
  wire faultSt   = (state_ff == S_IDLE) ? reqWr : curWr;
  wire clrCause  = apbWr && (paddr == `PHP_OFF_DCAUSE);
  wire clrSaved  = apbWr && (paddr == `PHP_OFF_SAVED);
  wire [31:0] setCause = ({31'h00000000, faultData} << `PHP_CAUSE_PROT)
                       | ({31'h00000000, faultData && faultSt} << `PHP_CAUSE_STORE);
  wire [31:0] setSaved = ({31'h00000000, faultInst} << `PHP_CAUSE_PROT);

  // sequencer, bus and answer registers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= S_IDLE;
      kind_ff      <= `PHP_K_LOAD;
      addr_ff      <= `PHP_ZERO32;
      key_ff       <= 1'b0;
      hit_ff       <= 1'b0;
      pendProt_ff  <= 1'b0;
      pendAlign_ff <= 1'b0;
      pendPhys_ff  <= `PHP_ZERO32;
      busReq       <= 1'b0;
      busWrite     <= 1'b0;
      busAddr      <= `PHP_ZERO32;
      busWdata     <= `PHP_ZERO32;
      rspValid     <= 1'b0;
      rspPhysAddr  <= `PHP_ZERO32;
      rspDataExc   <= 1'b0;
      rspInstrExc  <= 1'b0;
      rspAlignExc  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      kind_ff      <= nxt_kind;
      addr_ff      <= nxt_addr;
      key_ff       <= nxt_key;
      hit_ff       <= nxt_hit;
      pendProt_ff  <= nxt_pendProt;
      pendAlign_ff <= nxt_pendAlign;
      pendPhys_ff  <= nxt_pendPhys;
      busReq       <= nxt_busReq;
      busWrite     <= nxt_busWrite;
      busAddr      <= nxt_busAddr;
      busWdata     <= nxt_busWdata;
      rspValid     <= fin;
      rspPhysAddr  <= fin ? finPhys : rspPhysAddr;
      rspDataExc   <= faultData;
      rspInstrExc  <= faultInst;
      rspAlignExc  <= fin && finAlign;
    end
  end

  // cache valid bits; an invalidate loses to nothing but a same-cycle fill
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cacheVld_ff <= {DEPTH{1'b0}};
    end else if (cacheWe) begin
      cacheVld_ff <= (invAll ? {DEPTH{1'b0}} : cacheVld_ff) | ({{(DEPTH-1){1'b0}}, 1'b1} << cacheWIdx);
    end else if (invAll) begin
      cacheVld_ff <= {DEPTH{1'b0}};
    end
  end

  // tag and entry word storage needs no reset, the valid bits guard it
  always @(posedge sys_clk) begin
    if (cacheWe) begin
      cacheTag_ff[cacheWIdx] <= cacheWTag;
      cacheW1_ff[cacheWIdx]  <= cacheWData;
    end
  end

  // software registers; hardware set wins over a write-one-to-clear
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptBase_ff          <= `PHP_PTBASE_RST;
      dataFaultCause_ff  <= `PHP_ZERO32;
      faultSavedState_ff <= `PHP_ZERO32;
      lastShared_ff      <= 1'b0;
    end else begin
      if (apbWr && (paddr == `PHP_OFF_PTBASE)) begin
        ptBase_ff <= pwdata;
      end
      dataFaultCause_ff  <= (dataFaultCause_ff & ~(clrCause ? pwdata : `PHP_ZERO32)) | setCause;
      faultSavedState_ff <= (faultSavedState_ff & ~(clrSaved ? pwdata : `PHP_ZERO32)) | setSaved;
      // shared indication only observed, the bus side keeps it low when exclusive
      if ((state_ff == S_READ) && busAck) begin
        lastShared_ff <= shared_resp;
      end
    end
  end

  // read mux captured at setup, unmapped offsets answer with an error
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= `PHP_ZERO32;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pslverr <= 1'b0;
      case (paddr)
        `PHP_OFF_CTRL:   prdata <= `PHP_ZERO32;
        `PHP_OFF_PTBASE: prdata <= ptBase_ff;
        `PHP_OFF_DCAUSE: prdata <= dataFaultCause_ff;
        `PHP_OFF_SAVED:  prdata <= faultSavedState_ff;
        `PHP_OFF_STATUS: prdata <= (`PHP_ZERO32 | ({31'h00000000, state_ff != S_IDLE} << `PHP_STAT_BUSY))
                                 | ({31'h00000000, lastShared_ff} << `PHP_STAT_SHARED);
        default: begin
          prdata  <= `PHP_ZERO32;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ### test/php_chk_sva.sv
// assertion checker for the page history and protection block
`timescale 1ns/10ps
`include "php_regs.vh"
module php_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic [2:0]  reqKind,
  input wire logic        reqBlockMapHit,
  input wire logic        reqIoSeg,
  input wire logic        dataXlateOn,
  input wire logic        rspValid,
  input wire logic        rspDataExc,
  input wire logic        rspInstrExc,
  input wire logic        rspAlignExc,
  input wire logic        busReq,
  input wire logic        busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic        busGlobal,
  input wire logic        busRwitm,
  input wire logic        busSingleBeat,
  input wire logic        busAck,
  input wire logic [31:0] busRdata
);
  logic [31:0] rdWord_ff;
  logic [31:0] rdAddr_ff;
  logic [2:0]  kind_ff;
  wire         taken = reqValid && reqReady;
  // last entry read and last kind taken, so a write can be tied to its read
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdWord_ff <= 32'h00000000;
      rdAddr_ff <= 32'h00000000;
      kind_ff   <= 3'h0;
    end else begin
      if (busAck && !busWrite) rdWord_ff <= busRdata;
      if (busAck && !busWrite) rdAddr_ff <= busAddr;
      if (taken) kind_ff <= reqKind;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  bus_kind_a: assert property (busGlobal && !busRwitm && busSingleBeat)
    else $error("bus attributes wrong");
  bus_hold_a: assert property (busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWdata))
    else $error("bus request not held");
  word_keep_a: assert property (busReq && busWrite |-> busAddr == rdAddr_ff
    && (busWdata & 32'hFFFFFE7F) == (rdWord_ff & 32'hFFFFFE7F)) else $error("entry write changed fields");
  ref_set_a: assert property (busReq && busWrite |-> busWdata[8] && (busWdata[7] || !rdWord_ff[7]))
    else $error("touched flag not kept");
  second_word_a: assert property (busReq |-> busAddr[2:0] == 3'h4)
    else $error("entry access not second word");
  pass_thru_a: assert property (taken && (reqBlockMapHit || reqIoSeg) |=> rspValid && !busReq && !rspDataExc)
    else $error("pass through touched history");
  xlate_off_a: assert property (taken && reqKind != `PHP_K_FETCH && !dataXlateOn |=> rspValid && !busReq)
    else $error("history kept with translation off");
  touch_a: assert property (taken && (reqKind == `PHP_K_TOUCHL || reqKind == `PHP_K_TOUCHS)
    |=> rspValid && !busReq && !rspDataExc) else $error("touch op searched");
  instr_exc_a: assert property (rspInstrExc |-> rspValid && kind_ff == `PHP_K_FETCH && !rspDataExc)
    else $error("instruction fault on wrong kind");
  data_exc_a: assert property (rspDataExc |-> rspValid && kind_ff != `PHP_K_FETCH)
    else $error("data fault on fetch");
  align_a: assert property (rspAlignExc |-> rspValid && kind_ff == `PHP_K_ZERO)
    else $error("alignment fault on wrong kind");
  cover property (busReq && busWrite && busAck);
  cover property (rspValid && rspDataExc);
  cover property (rspValid && rspAlignExc);
endmodule
bind php_page_history_protect php_chk chk (.sys_clk, .arst_n, .reqValid, .reqReady, .reqKind, .reqBlockMapHit,
  .reqIoSeg, .dataXlateOn, .rspValid, .rspDataExc, .rspInstrExc, .rspAlignExc, .busReq, .busWrite, .busAddr,
  .busWdata, .busGlobal, .busRwitm, .busSingleBeat, .busAck, .busRdata);

// ### test/php_bus_mem.sv
// bus and main memory model answering the block's entry reads and writes
`timescale 1ns/10ps
module php_bus_mem (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        busReq,
  input  wire logic        busWrite,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic [3:0]  lag,
  output logic             busAck,
  output logic [31:0]      busRdata,
  output logic             shared_resp
);
  logic [31:0] mem [0:31];
  logic [3:0]  waitCnt;
  int          nRd = 0;
  int          nWr = 0;
  // one beat per request after lag idle cycles; no locked cycles exist here
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busAck      <= 1'b0;
      busRdata    <= 32'h00000000;
      shared_resp <= 1'b0;
      waitCnt     <= 4'h0;
    end else begin
      busAck      <= 1'b0;
      busRdata    <= ~busRdata;  // data is junk off the ack cycle
      shared_resp <= 1'b0;
      if (busReq && !busAck) begin
        if (waitCnt != lag) begin
          waitCnt <= waitCnt + 4'h1;
        end else begin
          waitCnt <= 4'h0;
          busAck  <= 1'b1;
          if (busWrite) begin
            mem[busAddr[7:3]] <= busWdata;
            nWr = nWr + 1;
          end else begin
            busRdata <= mem[busAddr[7:3]];
            nRd = nRd + 1;
          end
        end
      end
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the page history and protection block
`timescale 1ns/10ps
`include "php_regs.vh"
module testbench;
  logic        sys_clk = 1'b0, arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, busAddr, busWdata, busRdata, rspPhysAddr;
  logic        pready, pslverr, reqReady, rspValid, rspDataExc, rspInstrExc, rspAlignExc;
  logic        reqValid = 1'b0, reqKey = 1'b0, reqBlockMapHit = 1'b0, reqIoSeg = 1'b0;
  logic        instrXlateOn = 1'b1, dataXlateOn = 1'b1;
  logic [2:0]  reqKind = 3'h0;
  logic [31:0] reqAddr = 32'h00000000, rdv, phys;
  logic        busReq, busWrite, busGlobal, busRwitm, busSingleBeat, busAck, shared_resp, errv, excD, excI, excA;
  logic [3:0]  lag = 4'h0;
  int          err_total = 0, n_checks = 0, r0, w0;
  php_page_history_protect dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reqValid, .reqReady, .reqKind, .reqAddr, .reqKey, .reqBlockMapHit, .reqIoSeg, .instrXlateOn,
    .dataXlateOn, .rspValid, .rspPhysAddr, .rspDataExc, .rspInstrExc, .rspAlignExc, .busReq, .busWrite, .busAddr,
    .busWdata, .busGlobal, .busRwitm, .busSingleBeat, .busAck, .busRdata, .shared_resp);
  php_bus_mem mdl (.sys_clk, .arst_n, .busReq, .busWrite, .busAddr, .busWdata, .lag, .busAck, .busRdata,
    .shared_resp);
  always #50 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one pipeline request; f is {instr on, data on, io segment, block map}
  task automatic go(input logic [2:0] k, input logic [7:0] pg, input logic key, input logic [3:0] f);
    int n;
    r0 = mdl.nRd;
    w0 = mdl.nWr;
    @(posedge sys_clk);
    reqKind <= k;
    reqAddr <= {12'h000, pg, 12'h234};
    reqKey <= key;
    {instrXlateOn, dataXlateOn, reqIoSeg, reqBlockMapHit} <= f;
    reqValid <= 1'b1;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 300);
    check("answer", 1, rspValid);
    {excD, excI, excA} = {rspDataExc, rspInstrExc, rspAlignExc};
    phys = rspPhysAddr;
  endtask
  task automatic bus(input int dr, input int dw);
    check("bus reads", 32'(dr), 32'(mdl.nRd - r0));
    check("bus writes", 32'(dw), 32'(mdl.nWr - w0));
  endtask
  task automatic t_regs;
    apb(1'b0, `PHP_OFF_PTBASE, 32'h0);
    check("ptbase reset", `PHP_PTBASE_RST, rdv);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", 1, errv);
    check("unmapped data", 0, rdv);
    apb(1'b1, `PHP_OFF_PTBASE, 32'h00001000);
    apb(1'b0, `PHP_OFF_PTBASE, 32'h0);
    check("ptbase", 32'h00001000, rdv);
  endtask
  task automatic t_hist;
    mdl.mem[1] = 32'hA0001002;
    go(`PHP_K_LOAD, 8'h01, 1'b0, 4'hC);
    bus(1, 1);
    check("entry 1", 32'hA0001102, mdl.mem[1]);
    check("phys", 32'hA0001234, phys);
    apb(1'b0, `PHP_OFF_STATUS, 32'h0);
    check("status", 0, rdv);
    go(`PHP_K_LOAD, 8'h01, 1'b0, 4'hC);
    bus(0, 0);
    go(`PHP_K_STORE, 8'h01, 1'b0, 4'hC);
    bus(1, 1);
    check("entry 1", 32'hA0001182, mdl.mem[1]);
    check("store ok", 0, excD);
    go(`PHP_K_STORE, 8'h01, 1'b0, 4'hC);
    bus(0, 0);
    // memory copy cleared behind the cache: the cached flag still rules
    mdl.mem[1] = 32'hA0001102;
    go(`PHP_K_STORE, 8'h01, 1'b0, 4'hC);
    bus(0, 0);
    apb(1'b1, `PHP_OFF_CTRL, 32'h00000001);
    go(`PHP_K_STORE, 8'h01, 1'b0, 4'hC);
    check("entry 1", 32'hA0001182, mdl.mem[1]);
  endtask
  task automatic t_prot;
    @(posedge sys_clk);
    lag <= 4'h3;
    mdl.mem[2] = 32'hA0002003;
    go(`PHP_K_STORE, 8'h02, 1'b0, 4'hC);
    check("store fault", 1, excD);
    check("entry 2", 32'hA0002103, mdl.mem[2]);
    apb(1'b0, `PHP_OFF_DCAUSE, 32'h0);
    check("cause", 32'h0A000000, rdv);
    apb(1'b1, `PHP_OFF_DCAUSE, 32'h0A000000);
    apb(1'b0, `PHP_OFF_DCAUSE, 32'h0);
    check("cause clear", 0, rdv);
    mdl.mem[3] = 32'hA0003000;
    go(`PHP_K_LOAD, 8'h03, 1'b1, 4'hC);
    check("load fault", 1, excD);
    check("entry 3", 32'hA0003100, mdl.mem[3]);
    apb(1'b0, `PHP_OFF_DCAUSE, 32'h0);
    check("cause", 32'h08000000, rdv);
    go(`PHP_K_FETCH, 8'h03, 1'b1, 4'hC);
    check("fetch fault", 1, excI);
    go(`PHP_K_LOAD, 8'h03, 1'b1, 4'hC);
    check("load hit fault", 1, excD);
    check("load hit no instr", 0, excI);
    apb(1'b0, `PHP_OFF_SAVED, 32'h0);
    check("saved", 32'h08000000, rdv);
  endtask
  task automatic t_misc;
    @(posedge sys_clk);
    lag <= 4'h0;
    mdl.mem[4] = 32'hA0004002;
    go(`PHP_K_TOUCHL, 8'h04, 1'b0, 4'hC);
    go(`PHP_K_TOUCHS, 8'h04, 1'b0, 4'hC);
    check("entry 4", 32'hA0004002, mdl.mem[4]);
    mdl.mem[5] = 32'hA0005042;
    go(`PHP_K_ZERO, 8'h05, 1'b0, 4'hC);
    check("zero align", 1, excA);
    check("entry 5 dirty", 0, {31'h0, mdl.mem[5][7]});
    go(`PHP_K_STORE, 8'h06, 1'b0, 4'hD);
    bus(0, 0);
    check("pass phys", 32'h00006234, phys);
    go(`PHP_K_STORE, 8'h06, 1'b0, 4'hE);
    bus(0, 0);
    go(`PHP_K_STORE, 8'h06, 1'b0, 4'h8);
    bus(0, 0);
    go(`PHP_K_FETCH, 8'h06, 1'b0, 4'h4);
    bus(0, 0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs;
    t_hist;
    t_prot;
    t_misc;
    conclude;
  end
  // watchdog: whole run needs well under a thousand cycles
  initial begin
    #2000000;
    err_total++;
    conclude;
  end
endmodule
